// File: pbg_pkg.sv
// Purpose: Constants shared by the peripheral bridge access guard.
// Assumes: One bus clock, synchronous active-high reset.
// Notes:   Master and peripheral counts are fixed.
`default_nettype none
package pbg_pkg;
	localparam int NUM_MASTERS = 4;
	localparam int MID_W       = 2;
	localparam int NUM_PERIPH  = 8;
	localparam int PID_W       = 3;
	localparam int ADDR_W      = 16;
	localparam int DATA_W      = 32;
	localparam logic [NUM_MASTERS-1:0] RST_TRUST_RD = 4'hf;
	localparam logic [NUM_MASTERS-1:0] RST_TRUST_WR = 4'hf;
	localparam logic [NUM_PERIPH-1:0]  RST_SUPV     = 8'h00;
	localparam logic [NUM_PERIPH-1:0]  RST_WPROT    = 8'h00;
	localparam logic [NUM_PERIPH-1:0]  RST_NOTRUST  = 8'h00;
	localparam int PID_LSB = 12;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FWD  = 3'b010,
		ST_RESP = 3'b100
	} pbg_state_type;
endpackage
`default_nettype wire

// File: pbg_check.sv
// Purpose: Combinational permission check for one access.
// Assumes: Settings are stable registered inputs.
// Notes:   Kept separate so the decision is one small cone of logic.
`timescale 1ns/1ns
`default_nettype none
module pbg_check (
	input  wire logic [pbg_pkg::NUM_MASTERS-1:0] trust_rd,
	input  wire logic [pbg_pkg::NUM_MASTERS-1:0] trust_wr,
	input  wire logic [pbg_pkg::NUM_PERIPH-1:0]  supv_req,
	input  wire logic [pbg_pkg::NUM_PERIPH-1:0]  wprot,
	input  wire logic [pbg_pkg::NUM_PERIPH-1:0]  no_untrust,
	input  wire logic [pbg_pkg::MID_W-1:0]       mid,
	input  wire logic [pbg_pkg::PID_W-1:0]       pid,
	input  wire logic                            write,
	input  wire logic                            supv,
	output logic                                 allow
);
	wire master_trusted;
	wire supv_fail;
	wire wp_fail;
	wire trust_fail;
	assign master_trusted = write ? trust_wr[mid] : trust_rd[mid];
	assign supv_fail      = supv_req[pid] & ~supv;
	assign wp_fail        = wprot[pid] & write;
	assign trust_fail     = no_untrust[pid] & ~master_trusted;
	assign allow          = ~(supv_fail | wp_fail | trust_fail);
endmodule // pbg_check
`default_nettype wire

// File: pbg_gate.sv
// Purpose: Peripheral bridge gate checking every master access against protection settings.
// Assumes: Master holds its request until answered; peripheral answers with PER_DONE.
// Notes:   One access in flight; a refused access ends with an error and no peripheral cycle.
//
// Functional notes
// - Protection applies separately to each attached peripheral module.
// - Each master has its own read-trusted and write-trusted setting.
// - Each peripheral, on or off platform, has its own access-level setting.
// - Supervisor-required peripheral accepts only accesses carrying the supervisor attribute.
// - Write-protected peripheral has every write terminated.
// - Untrusted-blocking peripheral refuses masters untrusted for that access type.
`timescale 1ns/1ns
`default_nettype none
module pbg_gate (
	input  wire logic                            CORE_CLK,
	input  wire logic                            SRST,
	input  wire logic                            CFG_WE,
	input  wire logic [pbg_pkg::NUM_MASTERS-1:0] CFG_TRUST_RD,
	input  wire logic [pbg_pkg::NUM_MASTERS-1:0] CFG_TRUST_WR,
	input  wire logic [pbg_pkg::NUM_PERIPH-1:0]  CFG_SUPV,
	input  wire logic [pbg_pkg::NUM_PERIPH-1:0]  CFG_WPROT,
	input  wire logic [pbg_pkg::NUM_PERIPH-1:0]  CFG_NOTRUST,
	input  wire logic                            M_REQ,
	input  wire logic [pbg_pkg::MID_W-1:0]       M_ID,
	input  wire logic                            M_WRITE,
	input  wire logic                            M_SUPV,
	input  wire logic [pbg_pkg::ADDR_W-1:0]      M_ADDR,
	input  wire logic [pbg_pkg::DATA_W-1:0]      M_WDATA,
	output logic                                 M_DONE,
	output logic                                 M_ERR,
	output logic [pbg_pkg::DATA_W-1:0]           M_RDATA,
	output logic                                 PER_REQ,
	output logic                                 PER_WRITE,
	output logic [pbg_pkg::ADDR_W-1:0]           PER_ADDR,
	output logic [pbg_pkg::DATA_W-1:0]           PER_WDATA,
	input  wire logic                            PER_DONE,
	input  wire logic [pbg_pkg::DATA_W-1:0]      PER_RDATA,
	output logic [pbg_pkg::NUM_MASTERS-1:0]      STAT_TRUST_RD,
	output logic [pbg_pkg::NUM_MASTERS-1:0]      STAT_TRUST_WR,
	output logic [pbg_pkg::NUM_PERIPH-1:0]       STAT_SUPV,
	output logic [pbg_pkg::NUM_PERIPH-1:0]       STAT_WPROT,
	output logic [pbg_pkg::NUM_PERIPH-1:0]       STAT_NOTRUST
);
	pbg_pkg::pbg_state_type state_r;
	pbg_pkg::pbg_state_type state_nxt;
	logic [pbg_pkg::NUM_MASTERS-1:0] trust_rd_r;
	logic [pbg_pkg::NUM_MASTERS-1:0] trust_wr_r;
	logic [pbg_pkg::NUM_PERIPH-1:0]  supv_r;
	logic [pbg_pkg::NUM_PERIPH-1:0]  wprot_r;
	logic [pbg_pkg::NUM_PERIPH-1:0]  notrust_r;
	logic                            done_r;
	logic                            err_r;
	logic [pbg_pkg::DATA_W-1:0]      rdata_r;
	logic                            preq_r;
	logic                            pwrite_r;
	logic [pbg_pkg::ADDR_W-1:0]      paddr_r;
	logic [pbg_pkg::DATA_W-1:0]      pwdata_r;
	wire  [pbg_pkg::PID_W-1:0]       pid;
	wire                             allow;
	wire                             start;
	wire                             granted;
	wire                             refused;
	wire                             finish;

	// Peripheral select is taken from fixed address bits above each module's window.
	assign pid     = M_ADDR[pbg_pkg::PID_LSB +: pbg_pkg::PID_W];
	assign start   = (state_r == pbg_pkg::ST_IDLE) & M_REQ;
	assign granted = start & allow;
	assign refused = start & ~allow;
	assign finish  = (state_r == pbg_pkg::ST_FWD) & PER_DONE;

	pbg_check u_check (
		.trust_rd   (trust_rd_r),
		.trust_wr   (trust_wr_r),
		.supv_req   (supv_r),
		.wprot      (wprot_r),
		.no_untrust (notrust_r),
		.mid        (M_ID),
		.pid        (pid),
		.write      (M_WRITE),
		.supv       (M_SUPV),
		.allow      (allow)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			pbg_pkg::ST_IDLE: begin
				if (granted) begin
					state_nxt = pbg_pkg::ST_FWD;
				end else if (refused) begin
					state_nxt = pbg_pkg::ST_RESP;
				end
			end
			pbg_pkg::ST_FWD: begin
				if (PER_DONE) begin
					state_nxt = pbg_pkg::ST_RESP;
				end
			end
			pbg_pkg::ST_RESP: begin
				state_nxt = pbg_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = pbg_pkg::ST_IDLE;
			end
		endcase
	end

	// Settings change only between accesses so one access sees one consistent set.
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			trust_rd_r <= pbg_pkg::RST_TRUST_RD;
			trust_wr_r <= pbg_pkg::RST_TRUST_WR;
			supv_r     <= pbg_pkg::RST_SUPV;
			wprot_r    <= pbg_pkg::RST_WPROT;
			notrust_r  <= pbg_pkg::RST_NOTRUST;
		end else if (CFG_WE && state_r == pbg_pkg::ST_IDLE && !M_REQ) begin
			trust_rd_r <= CFG_TRUST_RD;
			trust_wr_r <= CFG_TRUST_WR;
			supv_r     <= CFG_SUPV;
			wprot_r    <= CFG_WPROT;
			notrust_r  <= CFG_NOTRUST;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			state_r <= pbg_pkg::ST_IDLE;
			preq_r  <= 1'b0;
			done_r  <= 1'b0;
			err_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			preq_r  <= granted | (preq_r & ~PER_DONE);
			done_r  <= refused | finish;
			err_r   <= refused;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			pwrite_r <= 1'b0;
			paddr_r  <= 16'h0000;
			pwdata_r <= 32'h0000_0000;
			rdata_r  <= 32'h0000_0000;
		end else begin
			if (granted) begin
				pwrite_r <= M_WRITE;
				paddr_r  <= M_ADDR;
				pwdata_r <= M_WDATA;
			end
			if (finish) begin
				rdata_r <= PER_RDATA;
			end else if (refused) begin
				rdata_r <= 32'h0000_0000;
			end
		end
	end

	assign M_DONE        = done_r;
	assign M_ERR         = err_r;
	assign M_RDATA       = rdata_r;
	assign PER_REQ       = preq_r;
	assign PER_WRITE     = pwrite_r;
	assign PER_ADDR      = paddr_r;
	assign PER_WDATA     = pwdata_r;
	assign STAT_TRUST_RD = trust_rd_r;
	assign STAT_TRUST_WR = trust_wr_r;
	assign STAT_SUPV     = supv_r;
	assign STAT_WPROT    = wprot_r;
	assign STAT_NOTRUST  = notrust_r;

	a_wprot_block: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(start && M_WRITE && wprot_r[pid]) |=> (M_ERR && M_DONE && !PER_REQ))
		else $error("Protected write was not terminated.");
	a_supv_block: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(start && supv_r[pid] && !M_SUPV) |=> M_ERR)
		else $error("User access to supervisor peripheral not refused.");
	a_untrust_block: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(start && notrust_r[pid] && !(M_WRITE ? trust_wr_r[M_ID] : trust_rd_r[M_ID])) |=> M_ERR)
		else $error("Untrusted master not refused.");
	a_refuse_noper: assert property (@(posedge CORE_CLK) disable iff (SRST)
		refused |=> (!PER_REQ)[*2])
		else $error("Refused access reached the peripheral.");
	a_grant_fwd: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(granted && M_WRITE) |=> (PER_REQ && PER_WRITE && PER_ADDR == $past(M_ADDR)))
		else $error("Permitted access not forwarded.");
	a_trust_rd_ok: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(start && !M_WRITE && trust_rd_r[M_ID] && !supv_r[pid]) |=> !M_ERR)
		else $error("Trusted read wrongly refused.");
	a_cfg_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(state_r != pbg_pkg::ST_IDLE) |=> $stable(wprot_r) && $stable(supv_r))
		else $error("Settings changed during an access.");
	a_err_done: assert property (@(posedge CORE_CLK) disable iff (SRST)
		M_ERR |-> M_DONE ##1 !M_DONE)
		else $error("Error response not a single done pulse.");
	c_refused: cover property (@(posedge CORE_CLK) refused);
	c_read_ok: cover property (@(posedge CORE_CLK) finish && !PER_WRITE);
	c_write_ok: cover property (@(posedge CORE_CLK) finish && PER_WRITE);
endmodule // pbg_gate
`default_nettype wire

// File: pbg_per_model.sv
// Purpose: Behavioural peripheral that answers the accesses forwarded by the gate.
// Assumes: The gate holds its forwarded request until the edge after the completion pulse.
// Notes:   Read data is a function of the address; the data bus shows a moving pattern otherwise.
`timescale 1ns/1ns
`default_nettype none
module pbg_per_model (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       req,
	input  wire logic [pbg_pkg::ADDR_W-1:0] addr,
	input  wire logic [3:0]                 lat,
	output logic                            done,
	output logic [pbg_pkg::DATA_W-1:0]      rdata
);
	logic [3:0]                  cnt_r;
	logic [pbg_pkg::DATA_W-1:0]  junk_r;
	// A stale value on the data bus could hide a late capture, so it keeps changing.
	always_ff @(posedge clk) begin
		junk_r <= srst ? 32'h0000_0001 : {junk_r[30:0], ~junk_r[31]};
		cnt_r  <= (srst || !req || done) ? 4'h0 : cnt_r + 4'h1;
	end
	assign done  = req && (cnt_r == lat);
	assign rdata = done ? {addr, ~addr} : junk_r;
endmodule // pbg_per_model
`default_nettype wire

// File: pbg_gate_tb_top.sv
// Purpose: Self-checking bench for the peripheral bridge gate.
// Assumes: Settings are loaded only while the gate is idle and no request is pending.
// Notes:   Random settings and accesses come from a fixed-seed shift register.
`timescale 1ns/1ns
`default_nettype none
module pbg_gate_tb_top;
	logic        clk = 1'b0, srst = 1'b1, cfg_we = 1'b0, m_req = 1'b0, m_write = 1'b0, m_supv = 1'b0;
	logic [3:0]  trd, twr, lat = 4'h0, st_trd, st_twr;
	logic [7:0]  sv, wp, nt, st_sv, st_wp, st_nt;
	logic [1:0]  mid = 2'h0;
	logic [15:0] addr = 16'h0, per_addr;
	logic [31:0] wdata = 32'h0, seed, m_rdata, per_wdata, per_rdata;
	logic        m_done, m_err, per_req, per_write, per_done;
	int          err_count = 0, n_compared = 0;
	always #20 clk = ~clk;
	pbg_gate dut (.CORE_CLK(clk), .SRST(srst), .CFG_WE(cfg_we), .CFG_TRUST_RD(trd), .CFG_TRUST_WR(twr),
		.CFG_SUPV(sv), .CFG_WPROT(wp), .CFG_NOTRUST(nt), .M_REQ(m_req), .M_ID(mid), .M_WRITE(m_write),
		.M_SUPV(m_supv), .M_ADDR(addr), .M_WDATA(wdata), .M_DONE(m_done), .M_ERR(m_err), .M_RDATA(m_rdata),
		.PER_REQ(per_req), .PER_WRITE(per_write), .PER_ADDR(per_addr), .PER_WDATA(per_wdata),
		.PER_DONE(per_done), .PER_RDATA(per_rdata), .STAT_TRUST_RD(st_trd), .STAT_TRUST_WR(st_twr),
		.STAT_SUPV(st_sv), .STAT_WPROT(st_wp), .STAT_NOTRUST(st_nt));
	pbg_per_model per (.clk(clk), .srst(srst), .req(per_req), .addr(per_addr), .lat(lat), .done(per_done),
		.rdata(per_rdata));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic expect_ok(input logic [1:0] m, input logic [2:0] p, input logic w, input logic s);
		return !(sv[p] && !s) && !(w && wp[p]) && !(nt[p] && !(w ? twr[m] : trd[m]));
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic results();
		$display("compared=%0d mismatches=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cfg(input logic [31:0] v);
		@(posedge clk);
		cfg_we <= 1'b1;
		{trd, twr, sv, wp, nt} <= v;
		@(posedge clk);
		cfg_we <= 1'b0;
		#1;
		chk({st_trd, st_twr, st_sv, st_wp, st_nt}, {trd, twr, sv, wp, nt});
	endtask
	task automatic acc(input logic [1:0] m, input logic w, input logic s, input logic [15:0] a, input logic [31:0] d);
		logic ok;
		int   n;
		ok = expect_ok(m, a[14:12], w, s);
		@(posedge clk);
		{m_req, mid, m_write, m_supv, addr, wdata, lat} <= {1'b1, m, w, s, a, d, d[27:24]};
		for (n = 0; n < 40 && m_done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (ok && n == 0)
				chk({per_req, per_write, per_addr, per_wdata}, {1'b1, w, a, d});
			else if (!ok)
				chk(per_req, 1'b0);
		end
		chk({m_done, m_err}, {1'b1, !ok});
		if (!ok || !w)
			chk(m_rdata, ok ? {a, ~a} : 32'h0);
		// A refusal answers one edge after the take; a grant waits for the peripheral latency.
		chk(n, ok ? d[27:24] + 2 : 1);
		@(posedge clk);
		m_req <= 1'b0;
	endtask
	initial begin
		seed = 32'h789b;
		{trd, twr, sv, wp, nt} = 32'h0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		chk({st_trd, st_twr, st_sv, st_wp, st_nt, m_done, m_err, per_req}, {8'hff, 27'h0});
		// Slot 7 stands for the reset generation module: only the core may write it.
		cfg({4'hf, 4'h1, 8'h80, 8'h00, 8'h80});
		for (int m = 0; m < 4; m++)
			acc(m[1:0], 1'b1, 1'b1, 16'h7004, 32'h0000_1234);
		acc(2'h1, 1'b0, 1'b1, 16'h7008, 32'h0300_0000);
		acc(2'h1, 1'b0, 1'b0, 16'h7008, 32'h0000_0000);
		cfg({4'hf, 4'hf, 8'h01, 8'h02, 8'h00});
		acc(2'h0, 1'b0, 1'b0, 16'h0010, 32'h0);
		acc(2'h0, 1'b1, 1'b1, 16'h0010, 32'h0f00_0000);
		acc(2'h2, 1'b1, 1'b1, 16'h1000, 32'h0500_aaaa);
		acc(2'h2, 1'b0, 1'b0, 16'h1ffc, 32'h0);
		repeat (300) begin
			seed = lfsr(seed);
			if (seed[3:0] == 4'h0)
				cfg(lfsr(seed));
			else
				acc(seed[5:4], seed[6], seed[7], seed[23:8], lfsr(seed));
		end
		// A second reset in mid-run must bring back the open default settings.
		@(posedge clk);
		srst <= 1'b1;
		{trd, twr, sv, wp, nt} <= {8'hff, 24'h0};
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		chk({st_trd, st_twr, st_sv, st_wp, st_nt, m_done, m_err, per_req}, {8'hff, 27'h0});
		acc(2'h3, 1'b1, 1'b0, 16'h7000, 32'h0100_5555);
		results();
	end
	// The run needs well under 10000 cycles; twice that means a hang.
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		results();
	end
endmodule // pbg_gate_tb_top
`default_nettype wire
